// ### common/adc_seq_pkg.sv
// Shared register map, field layout, reset values and timing constants of the converter sequencer
package adc_seq_pkg;

    // Register pointer values
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_ADC_CONFIG = 8'h01;
    localparam logic [7:0] ADDR_SHUNT_RESULT = 8'h02;
    localparam logic [7:0] ADDR_BUS_RESULT = 8'h03;
    localparam logic [7:0] ADDR_TEMP_RESULT = 8'h04;
    localparam logic [7:0] ADDR_CURRENT_RESULT = 8'h05;
    localparam logic [7:0] ADDR_POWER_RESULT = 8'h06;
    localparam logic [7:0] ADDR_DIAG = 8'h07;
    localparam logic [7:0] ADDR_THRESH_BASE = 8'h08;
    localparam int NUM_LIMITS = 6;

    // Field positions
    localparam int DELAY_LSB = 6;
    localparam int MODE_LSB = 12;
    localparam int MODE_CONT_BIT = 15;
    localparam int CT_BUS_LSB = 9;
    localparam int CT_SHUNT_LSB = 6;
    localparam int CT_TEMP_LSB = 3;
    localparam int AVG_LSB = 0;
    localparam int DIAG_HOLD_BIT = 15;
    localparam int DIAG_DOA_BIT = 14;
    localparam int DIAG_AVGCMP_BIT = 13;
    localparam int DIAG_POL_BIT = 12;
    localparam int DIAG_OVF_BIT = 9;
    localparam int DIAG_LIMIT_LSB = 2;
    localparam int DIAG_DONE_BIT = 1;
    localparam int DIAG_TRIM_BIT = 0;

    // Limit flag indices
    localparam int LIM_SHUNT_LOW = 0;
    localparam int LIM_SHUNT_HIGH = 1;
    localparam int LIM_BUS_HIGH = 2;
    localparam int LIM_BUS_LOW = 3;
    localparam int LIM_TEMP_HIGH = 4;
    localparam int LIM_POWER_HIGH = 5;

    // Reset values
    localparam logic [7:0] RST_DELAY = 8'h00;
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [2:0] RST_CT = 3'h5;
    localparam logic [2:0] RST_AVG = 3'h0;
    localparam logic [15:0] RST_SHUNT_LOW = 16'h8000;
    localparam logic [15:0] RST_SHUNT_HIGH = 16'h7FFF;
    localparam logic [15:0] RST_BUS_HIGH = 16'h7FFF;
    localparam logic [15:0] RST_BUS_LOW = 16'h0000;
    localparam logic [15:0] RST_TEMP_HIGH = 16'hFFFF;
    localparam logic [15:0] RST_POWER_HIGH = 16'h7FFF;

    // Timing in its own units
    localparam int CLK_MHZ = 100;
    localparam int DELAY_STEP_US = 2000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONV = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    // Conversion time per code, microseconds
    function automatic int conv_time_us(input logic [2:0] code);
        case (code)
            3'h0: return 50;
            3'h1: return 84;
            3'h2: return 150;
            3'h3: return 280;
            3'h4: return 540;
            3'h5: return 1052;
            3'h6: return 2074;
            default: return 4120;
        endcase
    endfunction : conv_time_us

    // Averaging count as a right shift: 1,4,16,64,128,256,512,1024
    function automatic logic [3:0] avg_shift(input logic [2:0] code);
        case (code)
            3'h0: return 4'h0;
            3'h1: return 4'h2;
            3'h2: return 4'h4;
            3'h3: return 4'h6;
            3'h4: return 4'h7;
            3'h5: return 4'h8;
            3'h6: return 4'h9;
            default: return 4'hA;
        endcase
    endfunction : avg_shift

endpackage : adc_seq_pkg

// ### rtl/adc_sequencer_alert_monitor.sv
// Converter sequencer with averaging, start delay, limit monitor and alert pin
`timescale 1ns/1ps
`default_nettype none

module adc_sequencer_alert_monitor
    import adc_seq_pkg::*;
#(
    parameter int CLKS_PER_US = CLK_MHZ
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire reg_req_t reg_req_in,
    output logic [15:0] reg_rdata_out,
    input wire logic [15:0] adc_sample_in,
    input wire logic trim_memory_ok_in,
    output logic [1:0] adc_channel_out,
    output logic adc_busy_out,
    output logic alert_out,
    output logic alert_oe_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] conv_cycles(input logic [2:0] code);
        return 32'(conv_time_us(code) * CLKS_PER_US);
    endfunction : conv_cycles

    // Next enabled channel above 'from' (3'h7 starts from the first); 2'd3 means none
    function automatic logic [1:0] next_chan(input logic [2:0] mask, input logic [2:0] from);
        logic [1:0] r;
        r = 2'd3;
        for (int i = 2; i >= 0; i--) begin
            if (mask[i] && ((from == 3'h7) || (3'(i) > from))) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction : next_chan

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    localparam logic [2:0] FROM_START = 3'h7;
    localparam logic [31:0] DELAY_STEP_CYC = 32'(DELAY_STEP_US * CLKS_PER_US);

    logic [7:0] delay_q;
    logic [3:0] mode_q;
    logic [2:0] ct_bus_q, ct_shunt_q, ct_temp_q, avg_q;
    logic hold_q, doa_q, avgcmp_q, pol_q;
    logic [15:0] thr_q [NUM_LIMITS];
    logic [15:0] shunt_res_q, bus_res_q, temp_res_q, cur_res_q, pwr_res_q;
    logic [NUM_LIMITS-1:0] lim_q;
    logic done_q, ovf_q;
    seq_state_t state_q;
    logic [1:0] chan_q;
    logic [10:0] round_q;
    logic [31:0] cnt_q;
    logic signed [31:0] acc_q [4];
    logic signed [15:0] shunt_last_q;
    logic [15:0] rdata_q;
    logic alert_oe_q;

    logic cfg_wr, mode_wr, diag_rd;
    logic [3:0] new_mode;
    logic [1:0] first_new, first_cur, next_c;
    logic [31:0] conv_len;
    logic conv_end, last_round, seq_done;

    assign cfg_wr = reg_req_in.wr && (reg_req_in.addr == ADDR_ADC_CONFIG);
    assign new_mode = reg_req_in.wdata[MODE_LSB +: 4];
    assign mode_wr = cfg_wr;
    assign diag_rd = reg_req_in.rd && (reg_req_in.addr == ADDR_DIAG);
    assign first_new = next_chan(new_mode[2:0], FROM_START);
    assign first_cur = next_chan(mode_q[2:0], FROM_START);
    assign next_c = next_chan(mode_q[2:0], {1'b0, chan_q});
    assign conv_len = (chan_q == 2'd0) ? conv_cycles(ct_shunt_q) :
                      (chan_q == 2'd1) ? conv_cycles(ct_bus_q) : conv_cycles(ct_temp_q);
    assign conv_end = (state_q == ST_CONV) && (cnt_q == conv_len - 32'd1);
    assign last_round = (round_q == 11'((32'd1 << avg_shift(avg_q)) - 32'd1));
    assign seq_done = conv_end && (next_c == 2'd3) && last_round;

    ////////////////////////////////////////////////////////////////////////////
    // Host writes

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            delay_q <= RST_DELAY;
            mode_q <= RST_MODE;
            ct_bus_q <= RST_CT;
            ct_shunt_q <= RST_CT;
            ct_temp_q <= RST_CT;
            avg_q <= RST_AVG;
            hold_q <= 1'b0;
            doa_q <= 1'b0;
            avgcmp_q <= 1'b0;
            pol_q <= 1'b0;
            thr_q[LIM_SHUNT_LOW] <= RST_SHUNT_LOW;
            thr_q[LIM_SHUNT_HIGH] <= RST_SHUNT_HIGH;
            thr_q[LIM_BUS_HIGH] <= RST_BUS_HIGH;
            thr_q[LIM_BUS_LOW] <= RST_BUS_LOW;
            thr_q[LIM_TEMP_HIGH] <= RST_TEMP_HIGH;
            thr_q[LIM_POWER_HIGH] <= RST_POWER_HIGH;
        end else if (reg_req_in.wr) begin
            if (reg_req_in.addr == ADDR_CONFIG) begin
                delay_q <= reg_req_in.wdata[DELAY_LSB +: 8];
            end
            if (cfg_wr) begin
                mode_q <= new_mode;
                ct_bus_q <= reg_req_in.wdata[CT_BUS_LSB +: 3];
                ct_shunt_q <= reg_req_in.wdata[CT_SHUNT_LSB +: 3];
                ct_temp_q <= reg_req_in.wdata[CT_TEMP_LSB +: 3];
                avg_q <= reg_req_in.wdata[AVG_LSB +: 3];
            end
            if (reg_req_in.addr == ADDR_DIAG) begin
                hold_q <= reg_req_in.wdata[DIAG_HOLD_BIT];
                doa_q <= reg_req_in.wdata[DIAG_DOA_BIT];
                avgcmp_q <= reg_req_in.wdata[DIAG_AVGCMP_BIT];
                pol_q <= reg_req_in.wdata[DIAG_POL_BIT];
            end
            for (int i = 0; i < NUM_LIMITS; i++) begin
                if (reg_req_in.addr == ADDR_THRESH_BASE + 8'(i)) begin
                    thr_q[i] <= reg_req_in.wdata;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= ST_IDLE;
            chan_q <= 2'd0;
            round_q <= 11'd0;
            cnt_q <= 32'd0;
        end else if (mode_wr) begin
            round_q <= 11'd0;
            cnt_q <= 32'd0;
            chan_q <= (first_new == 2'd3) ? 2'd0 : first_new;
            if (new_mode[2:0] == 3'h0) begin
                state_q <= ST_IDLE;
            end else if (delay_q != 8'h00) begin
                state_q <= ST_DELAY;
            end else begin
                state_q <= ST_CONV;
            end
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    cnt_q <= 32'd0;
                end
                ST_DELAY: begin
                    if (cnt_q == 32'(delay_q) * DELAY_STEP_CYC - 32'd1) begin
                        cnt_q <= 32'd0;
                        state_q <= ST_CONV;
                    end else begin
                        cnt_q <= cnt_q + 32'd1;
                    end
                end
                ST_CONV: begin
                    if (conv_end) begin
                        cnt_q <= 32'd0;
                        if (next_c != 2'd3) begin
                            chan_q <= next_c;
                        end else begin
                            chan_q <= first_cur;
                            if (!last_round) begin
                                round_q <= round_q + 11'd1;
                            end else begin
                                round_q <= 11'd0;
                                if (!mode_q[MODE_CONT_BIT - MODE_LSB]) begin
                                    state_q <= ST_IDLE;
                                end
                            end
                        end
                    end else begin
                        cnt_q <= cnt_q + 32'd1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Accumulation and results

    logic signed [15:0] sample;
    logic signed [31:0] prod, sum_ch, sum_pw, avg_ch, avg_pw;
    logic signed [15:0] pwr_sample;
    logic pwr_ovf;

    // Each sample is a fresh, fully settled conversion; the power product reuses the last shunt sample
    assign sample = $signed(adc_sample_in);
    assign prod = shunt_last_q * sample;
    assign pwr_sample = prod[30:15];
    assign pwr_ovf = conv_end && (chan_q == 2'd1) && (prod[31] != prod[30]);
    assign sum_ch = (round_q == 11'd0 ? 32'sd0 : acc_q[chan_q]) + 32'(sample);
    assign sum_pw = (round_q == 11'd0 ? 32'sd0 : acc_q[3]) + 32'(pwr_sample);
    assign avg_ch = sum_ch >>> avg_shift(avg_q);
    assign avg_pw = sum_pw >>> avg_shift(avg_q);

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < 4; i++) begin
                acc_q[i] <= 32'sd0;
            end
            shunt_last_q <= 16'sd0;
        end else if (conv_end) begin
            acc_q[chan_q] <= sum_ch;
            if (chan_q == 2'd0) begin
                shunt_last_q <= sample;
            end
            if (chan_q == 2'd1) begin
                acc_q[3] <= sum_pw;
            end
        end
    end

    // Results change only at the last round of a channel, never on a read
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shunt_res_q <= 16'h0000;
            bus_res_q <= 16'h0000;
            temp_res_q <= 16'h0000;
            cur_res_q <= 16'h0000;
            pwr_res_q <= 16'h0000;
        end else if (conv_end && last_round) begin
            unique case (chan_q)
                2'd0: begin
                    shunt_res_q <= avg_ch[15:0];
                    cur_res_q <= avg_ch[15:0];
                end
                2'd1: begin
                    bus_res_q <= avg_ch[15:0];
                    pwr_res_q <= avg_pw[15:0];
                end
                default: temp_res_q <= avg_ch[15:0];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Limit monitor and flags

    logic cmp_event;
    logic signed [15:0] cmp_val, cmp_pwr;
    logic [NUM_LIMITS-1:0] upd, hit;

    assign cmp_event = conv_end && (!avgcmp_q || last_round);
    assign cmp_val = avgcmp_q ? avg_ch[15:0] : sample;
    assign cmp_pwr = avgcmp_q ? avg_pw[15:0] : pwr_sample;

    always_comb begin
        upd = '0;
        hit = '0;
        if (cmp_event) begin
            unique case (chan_q)
                2'd0: begin
                    upd[LIM_SHUNT_LOW] = 1'b1;
                    upd[LIM_SHUNT_HIGH] = 1'b1;
                end
                2'd1: begin
                    upd[LIM_BUS_HIGH] = 1'b1;
                    upd[LIM_BUS_LOW] = 1'b1;
                    upd[LIM_POWER_HIGH] = 1'b1;
                end
                default: upd[LIM_TEMP_HIGH] = 1'b1;
            endcase
        end
        hit[LIM_SHUNT_LOW] = cmp_val < $signed(thr_q[LIM_SHUNT_LOW]);
        hit[LIM_SHUNT_HIGH] = cmp_val > $signed(thr_q[LIM_SHUNT_HIGH]);
        hit[LIM_BUS_HIGH] = cmp_val > $signed(thr_q[LIM_BUS_HIGH]);
        hit[LIM_BUS_LOW] = cmp_val < $signed(thr_q[LIM_BUS_LOW]);
        hit[LIM_TEMP_HIGH] = cmp_val > $signed(thr_q[LIM_TEMP_HIGH]);
        hit[LIM_POWER_HIGH] = cmp_pwr > $signed(thr_q[LIM_POWER_HIGH]);
    end

    // A new hit wins over a clearing read in the same cycle
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lim_q <= '0;
        end else begin
            for (int i = 0; i < NUM_LIMITS; i++) begin
                if (upd[i] && hit[i]) begin
                    lim_q[i] <= 1'b1;
                end else if (hold_q) begin
                    if (diag_rd) begin
                        lim_q[i] <= 1'b0;
                    end
                end else if (upd[i]) begin
                    lim_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            done_q <= 1'b0;
        end else if (seq_done) begin
            done_q <= 1'b1;
        end else if (diag_rd || (cfg_wr && new_mode[2:0] != 3'h0)) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ovf_q <= 1'b0;
        end else if (pwr_ovf) begin
            ovf_q <= 1'b1;
        end else if (diag_rd) begin
            ovf_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alert pin and read port

    logic alert_active;

    // Overflow deliberately left out of the alert term
    assign alert_active = (|lim_q) || (doa_q && done_q);

    // Open drain: the pin is pulled low whenever the driver is enabled
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            alert_oe_q <= 1'b0;
        end else begin
            alert_oe_q <= alert_active ^ pol_q;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_q <= 16'h0000;
        end else if (reg_req_in.rd) begin
            if (reg_req_in.addr == ADDR_CONFIG) begin
                rdata_q <= 16'({delay_q, 6'h00});
            end else if (reg_req_in.addr == ADDR_ADC_CONFIG) begin
                rdata_q <= {mode_q, ct_bus_q, ct_shunt_q, ct_temp_q, avg_q};
            end else if (reg_req_in.addr == ADDR_SHUNT_RESULT) begin
                rdata_q <= shunt_res_q;
            end else if (reg_req_in.addr == ADDR_BUS_RESULT) begin
                rdata_q <= bus_res_q;
            end else if (reg_req_in.addr == ADDR_TEMP_RESULT) begin
                rdata_q <= temp_res_q;
            end else if (reg_req_in.addr == ADDR_CURRENT_RESULT) begin
                rdata_q <= cur_res_q;
            end else if (reg_req_in.addr == ADDR_POWER_RESULT) begin
                rdata_q <= pwr_res_q;
            end else if (reg_req_in.addr == ADDR_DIAG) begin
                rdata_q <= {hold_q, doa_q, avgcmp_q, pol_q, 2'b00, ovf_q, 1'b0,
                            lim_q, done_q, trim_memory_ok_in};
            end else if (reg_req_in.addr >= ADDR_THRESH_BASE
                         && reg_req_in.addr < ADDR_THRESH_BASE + 8'(NUM_LIMITS)) begin
                rdata_q <= thr_q[3'(reg_req_in.addr - ADDR_THRESH_BASE)];
            end else begin
                rdata_q <= 16'h0000;
            end
        end
    end

    assign reg_rdata_out = rdata_q;
    assign adc_channel_out = chan_q;
    assign adc_busy_out = state_q[1];
    assign alert_out = 1'b0;
    assign alert_oe_out = alert_oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    a_done_on_seq: assert property (seq_done |=> done_q)
        else $error("done flag not set after sequence");
    a_done_clear: assert property (diag_rd && !seq_done |=> !done_q)
        else $error("done flag survived diag read");
    a_result_stable: assert property (!(conv_end && last_round) |=> $stable(shunt_res_q))
        else $error("shunt result changed without completion");
    a_trig_shutdown: assert property (seq_done && !mode_q[3] && !mode_wr |=> state_q == ST_IDLE)
        else $error("triggered mode did not shut down");
    a_restart_mode: assert property (mode_wr && new_mode[2:0] != 3'h0 |=> round_q == 11'd0
                                     && cnt_q == 32'd0 && state_q != ST_IDLE)
        else $error("mode write did not restart");
    a_idle_holds: assert property (state_q == ST_IDLE && !mode_wr |=> state_q == ST_IDLE)
        else $error("left shutdown without command");
    a_alert_polarity: assert property (##1 alert_oe_out == ($past(alert_active) ^ $past(pol_q)))
        else $error("alert drive disagrees with polarity");
    a_hold_keeps: assert property (hold_q && lim_q[LIM_SHUNT_HIGH] && !diag_rd
                                  |=> lim_q[LIM_SHUNT_HIGH])
        else $error("held flag dropped without read");
    a_ovf_no_alert: assert property (lim_q == '0 && !(doa_q && done_q) && ovf_q
                                    |=> alert_oe_out == $past(pol_q))
        else $error("overflow drove alert");
    a_done_alert: assert property (doa_q && done_q && !pol_q |=> alert_oe_out)
        else $error("completion did not assert alert");

    c_triggered_done: cover property (seq_done && !mode_q[3]);
    c_cont_repeat: cover property (seq_done && mode_q[3] ##1 state_q == ST_CONV);
    c_limit_hit: cover property (upd[LIM_BUS_LOW] && hit[LIM_BUS_LOW]);
    c_delay_start: cover property (state_q == ST_DELAY ##1 state_q == ST_CONV);

endmodule : adc_sequencer_alert_monitor

`default_nettype wire

// ### test/adc_front_model.sv
// Front-end model: fixed sample per channel and pulled-up alert wire
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
    input wire logic [1:0] channel_in,
    input wire logic alert_oe_in,
    output logic [15:0] sample_out,
    output logic alert_wire_out
);
    // Distinct value per channel so a result in the wrong register shows up
    always_comb begin
        case (channel_in)
            2'h0: sample_out = 16'h1234;
            2'h1: sample_out = 16'h2345;
            default: sample_out = 16'h0345;
        endcase
    end
    assign alert_wire_out = alert_oe_in ? 1'b0 : 1'b1;
endmodule : adc_front_model
`default_nettype wire

// ### test/adc_sequencer_alert_monitor_bench.sv
// Self-checking bench for the converter sequencer and alert monitor
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_alert_monitor_bench;
    import adc_seq_pkg::*;
    logic sys_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    reg_req_t req = '0;
    logic [15:0] rdata, sample;
    logic [1:0] chan;
    logic busy, alert, oe, wire_lvl, prev;
    logic trim_ok = 1'b1;
    int bad_count = 0;
    int n_compared = 0;
    int n0, n1;
    logic [15:0] thr [6] = '{16'h8000, 16'h7FFF, 16'h7FFF, 16'h0000, 16'hFFFF, 16'h7FFF};
    always #5 sys_clk_in = ~sys_clk_in;
    // One cycle per microsecond keeps the 2 ms delay step at 2000 cycles
    adc_sequencer_alert_monitor #(.CLKS_PER_US(1)) uut (.sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .adc_sample_in(sample), .trim_memory_ok_in(trim_ok), .adc_channel_out(chan),
        .adc_busy_out(busy), .alert_out(alert), .alert_oe_out(oe));
    adc_front_model model (.channel_in(chan), .alert_oe_in(oe), .sample_out(sample),
        .alert_wire_out(wire_lvl));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk_in);
        req <= '0;
        @(posedge sys_clk_in);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk_in);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge sys_clk_in);
        req <= '0;
        @(posedge sys_clk_in);
        #1 check(rdata, e);
    endtask : rd
    // Counts busy cycles; an offset of a few cycles cancels when two runs are compared
    task automatic run_conv(input logic [15:0] cfg, output int n);
        wr(ADDR_ADC_CONFIG, cfg);
        n = 0;
        do begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end while (busy === 1'b1 && n < 5000);
        if (n >= 5000) bad_count++;
        repeat (3) @(posedge sys_clk_in);
    endtask : run_conv
    task automatic print_verdict();
        if (bad_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        bad_count++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        @(posedge sys_clk_in);
        for (int i = 0; i < 6; i++) rd(ADDR_THRESH_BASE + 8'(i), thr[i]);
        rd(ADDR_DIAG, 16'h0001);
        run_conv(16'h1000, n0);
        rd(ADDR_SHUNT_RESULT, 16'h1234);
        rd(ADDR_BUS_RESULT, 16'h0000);
        rd(ADDR_DIAG, 16'h0003);
        rd(ADDR_DIAG, 16'h0001);
        run_conv(16'h1040, n1);
        check(16'(n1 - n0), 16'h0022);
        repeat (100) @(posedge sys_clk_in);
        #1 check({15'h0000, busy}, 16'h0000);
        wr(ADDR_THRESH_BASE + 8'h01, 16'h1000);
        run_conv(16'h1000, n0);
        check({15'h0000, wire_lvl}, 16'h0000);
        rd(ADDR_DIAG, 16'h000B);
        wr(ADDR_DIAG, 16'h1000);
        repeat (2) @(posedge sys_clk_in);
        #1 check({15'h0000, wire_lvl}, 16'h0001);
        wr(ADDR_THRESH_BASE + 8'h01, 16'h7FFF);
        wr(ADDR_DIAG, 16'h4000);
        // Shunt is converted again so the earlier shunt-high flag is cleared by a fresh compare
        run_conv(16'h3000, n0);
        check({15'h0000, wire_lvl}, 16'h0000);
        rd(ADDR_BUS_RESULT, 16'h2345);
        rd(ADDR_DIAG, 16'h4003);
        repeat (2) @(posedge sys_clk_in);
        #1 check({15'h0000, wire_lvl}, 16'h0001);
        wr(ADDR_CONFIG, 16'h0040);
        wr(ADDR_ADC_CONFIG, 16'h1000);
        repeat (1990) @(posedge sys_clk_in);
        #1 check({15'h0000, busy}, 16'h0000);
        repeat (30) @(posedge sys_clk_in);
        #1 check({15'h0000, busy}, 16'h0001);
        wr(ADDR_CONFIG, 16'h0000);
        wr(ADDR_ADC_CONFIG, 16'hB000);
        n0 = 0;
        prev = 1'b0;
        // Busy never drops in continuous mode, so count wraps from bus back to shunt
        repeat (300) begin
            @(posedge sys_clk_in);
            #1;
            if (chan === 2'd0 && prev === 1'b1) n0++;
            prev = chan[0];
        end
        check(16'(n0 >= 3), 16'h0001);
        wr(ADDR_ADC_CONFIG, 16'h0000);
        repeat (100) @(posedge sys_clk_in);
        #1 check({15'h0000, busy}, 16'h0000);
        wr(ADDR_DIAG, 16'h8000);
        trim_ok <= 1'b0;
        wr(ADDR_THRESH_BASE + 8'h01, 16'h1000);
        run_conv(16'h1000, n0);
        wr(ADDR_THRESH_BASE + 8'h01, 16'h7FFF);
        run_conv(16'h1000, n1);
        check({15'h0000, wire_lvl}, 16'h0000);
        rd(ADDR_DIAG, 16'h800A);
        rd(ADDR_DIAG, 16'h8000);
        check({15'h0000, wire_lvl}, 16'h0001);
        print_verdict();
    end
endmodule : adc_sequencer_alert_monitor_bench
`default_nettype wire
